/* verilog/nfc_pkg.sv */
// Constants, encodings and state layout for the NOR flash command interpreter
package nfc_pkg;
  // Geometry: 4 banks of 4 blocks of 256 words
  localparam int ADDR_W   = 12;
  localparam int NBANK    = 4;
  localparam int NBLK     = 16;
  localparam int BANK_LSB = 10;
  localparam int BLK_LSB  = 8;
  localparam int OFF_W    = 8;
  localparam logic [5:0] BUF_WORDS = 6'h20;

  // APB register byte offsets
  localparam logic [7:0] OFS_ADDR = 8'h00;
  localparam logic [7:0] OFS_DATA = 8'h04;
  localparam logic [7:0] OFS_CTRL = 8'h08;
  localparam logic [7:0] OFS_PROT = 8'h0c;
  localparam logic [7:0] OFS_STAT = 8'h10;
  localparam logic [7:0] OFS_MODE = 8'h14;

  // Control register fields and reset value
  localparam int CTRL_SUPPLY  = 0;
  localparam int CTRL_RESET_N = 1;
  localparam logic [1:0] CTRL_RST = 2'h2;

  // Status register bit positions and reset value
  localparam int SR_READY = 7;
  localparam int SR_ERASE = 5;
  localparam int SR_PROG  = 4;
  localparam int SR_VPP   = 3;
  localparam int SR_PROT  = 1;
  localparam logic [7:0] SR_RST    = 8'h80;
  localparam logic [7:0] SR_ERRMSK = 8'h3a;

  // Command codes
  localparam logic [7:0] C_ERASE  = 8'h20;
  localparam logic [7:0] C_PROG   = 8'h40;
  localparam logic [7:0] C_PROG2  = 8'h10;
  localparam logic [7:0] C_CLRST  = 8'h50;
  localparam logic [7:0] C_RDST   = 8'h70;
  localparam logic [7:0] C_EFP    = 8'h80;
  localparam logic [7:0] C_SIG    = 8'h90;
  localparam logic [7:0] C_CFI    = 8'h98;
  localparam logic [7:0] C_SUSP   = 8'hb0;
  localparam logic [7:0] C_BC     = 8'hbc;
  localparam logic [7:0] C_BCCONF = 8'hcb;
  localparam logic [7:0] C_CONF   = 8'hd0;
  localparam logic [7:0] C_BUF    = 8'he8;
  localparam logic [7:0] C_RDARR  = 8'hff;

  // Operation times in ns, and cycles at 50 MHz (least times round up)
  localparam int CLK_NS     = 20;
  localparam int T_ERASE_NS = 40000;
  localparam int T_PROG_NS  = 200;
  localparam int T_BC_NS    = 10000;
  localparam int T_BUF_NS   = 2000;
  localparam int T_EFP_NS   = 100;
  localparam logic [15:0] CY_ERASE = 16'((T_ERASE_NS + CLK_NS - 1) / CLK_NS);
  localparam logic [15:0] CY_PROG  = 16'((T_PROG_NS + CLK_NS - 1) / CLK_NS);
  localparam logic [15:0] CY_BC    = 16'((T_BC_NS + CLK_NS - 1) / CLK_NS);
  localparam logic [15:0] CY_BUF   = 16'((T_BUF_NS + CLK_NS - 1) / CLK_NS);
  localparam logic [15:0] CY_EFP   = 16'((T_EFP_NS + CLK_NS - 1) / CLK_NS);

  typedef enum logic [1:0] {MODE_ARRAY, MODE_STATUS, MODE_SIG, MODE_CFI} nfc_mode_t;
  typedef enum logic [2:0] {P_NONE, P_ERASE, P_PROG, P_BC, P_BUFCNT, P_BUFDATA, P_BUFCONF, P_EFP} nfc_pend_t;
  typedef enum logic [2:0] {OP_NONE, OP_ERASE, OP_PROG, OP_BC, OP_BUF, OP_EFP} nfc_op_t;

  typedef struct packed {
    nfc_op_t                  op;
    logic [1:0]               obank;
    logic [3:0]               oblk;
    logic [15:0]              timer;
    logic                     susp;
    logic [7:0]               status;
    nfc_mode_t [NBANK-1:0]    mode;
    nfc_pend_t [NBANK-1:0]    pend;
    logic [3:0]               bufblk;
    logic [4:0]               bufn;
    logic [5:0]               bufidx;
    logic [OFF_W-1:0]         bufstart;
    logic [NBLK-1:0]          blank;
    logic [NBLK-1:0]          prot;
    logic [1:0]               ctrl;
    logic [ADDR_W-1:0]        addr;
    logic [31:0]              prdata;
  } nfc_state_t;
endpackage

/* verilog/nfc_cmd_if.sv */
// Command interpreter of a multi-bank NOR flash, driven over APB
//
// The implementer's own choices: the register offsets and the APB slave port.
`timescale 1ns/1ps
module nfc_cmd_if (
  input  wire logic        pclk,
  input  wire logic        presetn,
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [7:0]  paddr,
  input  wire logic [31:0] pwdata,
  output logic      [31:0] prdata,
  output logic             pready,
  output logic             pslverr,
  output logic             controller_ready
);
  nfc_pkg::nfc_state_t q;
  nfc_pkg::nfc_state_t n;

  logic                acc_wr;
  logic                cmd_wr;
  logic [7:0]          cmd;
  logic [1:0]          cbank;
  logic [3:0]          cblk;
  logic [7:0]          coff;
  logic                mapped;
  logic                fin;

  // Start the controller or flag why it cannot run, except a blank check with supply low, which is dropped with no flag
  function automatic nfc_pkg::nfc_state_t start_op(nfc_pkg::nfc_state_t s, nfc_pkg::nfc_op_t op,
                                                   logic [1:0] bank, logic [3:0] blk);
    int failpos;
    failpos = (op == nfc_pkg::OP_ERASE) ? nfc_pkg::SR_ERASE : nfc_pkg::SR_PROG;
    if (s.op != nfc_pkg::OP_NONE) begin
      // Single controller: a second operation is refused while one runs
      s.status[failpos] = 1'b1;
    end else if (!s.ctrl[nfc_pkg::CTRL_SUPPLY]) begin
      if (op != nfc_pkg::OP_BC) begin
        s.status[nfc_pkg::SR_VPP] = 1'b1;
        s.status[failpos] = 1'b1;
      end
    end else if (s.prot[blk] && op != nfc_pkg::OP_BC) begin
      s.status[nfc_pkg::SR_PROT] = 1'b1;
      s.status[failpos] = 1'b1;
    end else begin
      s.op                      = op;
      s.obank                   = bank;
      s.oblk                    = blk;
      s.status[nfc_pkg::SR_READY] = 1'b0;
      case (op)
        nfc_pkg::OP_ERASE: s.timer = nfc_pkg::CY_ERASE - 16'h0001;
        nfc_pkg::OP_PROG:  s.timer = nfc_pkg::CY_PROG - 16'h0001;
        nfc_pkg::OP_BC:    s.timer = nfc_pkg::CY_BC - 16'h0001;
        nfc_pkg::OP_BUF:   s.timer = nfc_pkg::CY_BUF - 16'h0001;
        default:           s.timer = nfc_pkg::CY_EFP - 16'h0001;
      endcase
    end
    return s;
  endfunction

  // Bus decode: a flash bus write is an APB write to the data register
  assign acc_wr = psel && penable && pwrite;
  assign cmd_wr = acc_wr && (paddr == nfc_pkg::OFS_DATA);
  assign cmd    = pwdata[7:0];
  assign cbank  = q.addr[nfc_pkg::ADDR_W-1:nfc_pkg::BANK_LSB];
  assign cblk   = q.addr[nfc_pkg::ADDR_W-1:nfc_pkg::BLK_LSB];
  assign coff   = q.addr[nfc_pkg::OFF_W-1:0];
  assign mapped = (paddr == nfc_pkg::OFS_ADDR) || (paddr == nfc_pkg::OFS_DATA) || (paddr == nfc_pkg::OFS_CTRL) ||
                  (paddr == nfc_pkg::OFS_PROT) || (paddr == nfc_pkg::OFS_STAT) || (paddr == nfc_pkg::OFS_MODE);
  assign fin    = (q.op != nfc_pkg::OP_NONE) && !q.susp && (q.timer == 16'h0000);

  // Zero-wait slave; read data was captured in the setup cycle
  assign pready           = 1'b1;
  assign pslverr          = psel && penable && !mapped;
  assign prdata           = q.prdata;
  assign controller_ready = q.status[nfc_pkg::SR_READY];

  // Next-state logic: bus, command decode, controller progress
  always_comb begin
    logic [8:0] span;
    span = 9'h000;
    n    = q;

    // Read data latched during setup so it comes from a flop
    if (psel && !penable && !pwrite) begin
      case (paddr)
        nfc_pkg::OFS_ADDR: n.prdata = 32'(q.addr);
        nfc_pkg::OFS_DATA: n.prdata = (q.mode[cbank] == nfc_pkg::MODE_STATUS) ? 32'(q.status) : 32'h0000_0000;
        nfc_pkg::OFS_CTRL: n.prdata = 32'(q.ctrl);
        nfc_pkg::OFS_PROT: n.prdata = 32'(q.prot);
        nfc_pkg::OFS_STAT: n.prdata = {4'h0, q.blank, q.susp, q.op, q.status};
        nfc_pkg::OFS_MODE: n.prdata = {12'h000, q.pend, q.mode};
        default:           n.prdata = 32'h0000_0000;
      endcase
    end

    if (acc_wr) begin
      case (paddr)
        nfc_pkg::OFS_ADDR: n.addr = pwdata[nfc_pkg::ADDR_W-1:0];
        nfc_pkg::OFS_CTRL: n.ctrl = pwdata[1:0];
        nfc_pkg::OFS_PROT: n.prot = pwdata[nfc_pkg::NBLK-1:0];
        default: ;
      endcase
    end

    if (!q.ctrl[nfc_pkg::CTRL_RESET_N]) begin
      // Reset pin: abort, leave the target undefined, banks back to array
      if (q.op != nfc_pkg::OP_NONE) begin
        n.blank[q.oblk] = 1'b0;
      end
      n.op                      = nfc_pkg::OP_NONE;
      n.susp                    = 1'b0;
      n.status[nfc_pkg::SR_READY] = 1'b1;
      for (int b = 0; b < nfc_pkg::NBANK; b++) begin
        n.mode[b] = nfc_pkg::MODE_ARRAY;
        n.pend[b] = nfc_pkg::P_NONE;
      end
    end else begin
      if (cmd_wr) begin
        if (q.op == nfc_pkg::OP_BC || q.op == nfc_pkg::OP_EFP) begin
          // Blank check and factory setup lock out every bank; read status is taken only during blank check
          if (cmd == nfc_pkg::C_RDST && q.op == nfc_pkg::OP_BC) begin
            n.mode[cbank] = nfc_pkg::MODE_STATUS;
          end
        end else if (q.pend[cbank] != nfc_pkg::P_NONE) begin
          // Second and later writes of a sequence, tracked per bank
          n.pend[cbank] = nfc_pkg::P_NONE;
          n.mode[cbank] = nfc_pkg::MODE_STATUS;
          case (q.pend[cbank])
            nfc_pkg::P_ERASE: begin
              if (cmd == nfc_pkg::C_CONF) begin
                n = start_op(n, nfc_pkg::OP_ERASE, cbank, cblk);
              end else begin
                n.status[nfc_pkg::SR_ERASE] = 1'b1;
                n.status[nfc_pkg::SR_PROG]  = 1'b1;
              end
            end
            nfc_pkg::P_BC: begin
              if (cmd == nfc_pkg::C_BCCONF) begin
                n = start_op(n, nfc_pkg::OP_BC, cbank, cblk);
              end else begin
                n.status[nfc_pkg::SR_ERASE] = 1'b1;
                n.status[nfc_pkg::SR_PROG]  = 1'b1;
              end
            end
            nfc_pkg::P_PROG: n = start_op(n, nfc_pkg::OP_PROG, cbank, cblk);
            nfc_pkg::P_BUFCNT: begin
              if (cblk != q.bufblk || pwdata[15:0] >= 16'(nfc_pkg::BUF_WORDS)) begin
                n.status[nfc_pkg::SR_PROG] = 1'b1;
              end else begin
                n.bufn        = pwdata[4:0];
                n.bufidx      = 6'h00;
                n.pend[cbank] = nfc_pkg::P_BUFDATA;
              end
            end
            nfc_pkg::P_BUFDATA: begin
              span = {1'b0, coff} - {1'b0, (q.bufidx == 6'h00) ? coff : q.bufstart};
              if (cblk != q.bufblk || span[8] || span > {4'h0, q.bufn} ||
                  ({1'b0, coff} + {4'h0, q.bufn} > 9'h0ff && q.bufidx == 6'h00)) begin
                n.status[nfc_pkg::SR_PROG] = 1'b1;
              end else begin
                if (q.bufidx == 6'h00) begin
                  n.bufstart = coff;
                end
                n.bufidx      = q.bufidx + 6'h01;
                n.pend[cbank] = (q.bufidx == {1'b0, q.bufn}) ? nfc_pkg::P_BUFCONF : nfc_pkg::P_BUFDATA;
              end
            end
            nfc_pkg::P_BUFCONF: begin
              if (cmd == nfc_pkg::C_CONF && cblk == q.bufblk) begin
                n = start_op(n, nfc_pkg::OP_BUF, cbank, cblk);
              end else begin
                n.status[nfc_pkg::SR_PROG] = 1'b1;
              end
            end
            nfc_pkg::P_EFP: begin
              if (cmd == nfc_pkg::C_CONF) begin
                n = start_op(n, nfc_pkg::OP_EFP, cbank, cblk);
              end else begin
                n.status[nfc_pkg::SR_PROG] = 1'b1;
              end
            end
            default: ;
          endcase
        end else begin
          // First write of a command; a busy bank takes only reads and suspend
          case (cmd)
            nfc_pkg::C_RDARR: n.mode[cbank] = nfc_pkg::MODE_ARRAY;
            nfc_pkg::C_RDST:  n.mode[cbank] = nfc_pkg::MODE_STATUS;
            nfc_pkg::C_SIG:   n.mode[cbank] = nfc_pkg::MODE_SIG;
            nfc_pkg::C_CFI:   n.mode[cbank] = nfc_pkg::MODE_CFI;
            nfc_pkg::C_SUSP: begin
              if (q.op != nfc_pkg::OP_NONE) begin
                n.susp                    = 1'b1;
                n.status[nfc_pkg::SR_READY] = 1'b1;
              end
            end
            default: begin
              if (!(q.op != nfc_pkg::OP_NONE && q.obank == cbank)) begin
                case (cmd)
                  nfc_pkg::C_CLRST: n.status = q.status & ~nfc_pkg::SR_ERRMSK;
                  nfc_pkg::C_ERASE: n.pend[cbank] = nfc_pkg::P_ERASE;
                  nfc_pkg::C_PROG,
                  nfc_pkg::C_PROG2: n.pend[cbank] = nfc_pkg::P_PROG;
                  nfc_pkg::C_BC: begin
                    if (q.ctrl[nfc_pkg::CTRL_SUPPLY] && !q.susp) begin
                      n.pend[cbank] = nfc_pkg::P_BC;
                    end
                  end
                  nfc_pkg::C_BUF: begin
                    n.pend[cbank] = nfc_pkg::P_BUFCNT;
                    n.mode[cbank] = nfc_pkg::MODE_STATUS;
                    n.bufblk      = cblk;
                  end
                  nfc_pkg::C_EFP: n.pend[cbank] = nfc_pkg::P_EFP;
                  nfc_pkg::C_CONF: begin
                    if (q.susp) begin
                      n.susp                    = 1'b0;
                      n.status[nfc_pkg::SR_READY] = 1'b0;
                    end
                  end
                  default: ;
                endcase
              end
            end
          endcase
        end
      end

      // Controller progress after decode, so a finishing event beats a clear
      if (fin) begin
        case (q.op)
          nfc_pkg::OP_ERASE: n.blank[q.oblk] = 1'b1;
          nfc_pkg::OP_BC:    n.status[nfc_pkg::SR_ERASE] = n.status[nfc_pkg::SR_ERASE] | !q.blank[q.oblk];
          nfc_pkg::OP_PROG,
          nfc_pkg::OP_BUF:   n.blank[q.oblk] = 1'b0;
          default: ;
        endcase
        n.op                      = nfc_pkg::OP_NONE;
        n.status[nfc_pkg::SR_READY] = 1'b1;
      end else if (q.op != nfc_pkg::OP_NONE && !q.susp) begin
        n.timer = q.timer - 16'h0001;
      end
    end
  end

  // State register
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      q        <= '0;
      q.status <= nfc_pkg::SR_RST;
      q.ctrl   <= nfc_pkg::CTRL_RST;
      q.blank  <= '1;
    end else begin
      q <= n;
    end
  end

  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);

  a_ready_busy: assert property ((q.op != nfc_pkg::OP_NONE && !q.susp) |-> !q.status[nfc_pkg::SR_READY])
    else $error("ready bit high while controller runs");
  a_erase_badconf: assert property ((cmd_wr && q.ctrl[nfc_pkg::CTRL_RESET_N] && q.op == nfc_pkg::OP_NONE &&
      q.pend[cbank] == nfc_pkg::P_ERASE && cmd != nfc_pkg::C_CONF) |=> (q.status[5:4] == 2'b11 && q.op == nfc_pkg::OP_NONE))
    else $error("bad erase confirm not flagged");
  a_bc_badconf: assert property ((cmd_wr && q.ctrl[nfc_pkg::CTRL_RESET_N] && q.op == nfc_pkg::OP_NONE &&
      q.pend[cbank] == nfc_pkg::P_BC && cmd != nfc_pkg::C_BCCONF) |=> q.status[5:4] == 2'b11)
    else $error("bad blank check confirm not flagged");
  a_err_sticky: assert property ((q.status[nfc_pkg::SR_ERASE] && !(cmd_wr && cmd == nfc_pkg::C_CLRST)) |=>
      q.status[nfc_pkg::SR_ERASE])
    else $error("erase fail bit lost without clear");
  a_reset_abort: assert property ((!q.ctrl[nfc_pkg::CTRL_RESET_N] && q.op != nfc_pkg::OP_NONE) |=>
      (q.op == nfc_pkg::OP_NONE && !q.blank[$past(q.oblk)]))
    else $error("reset pin did not abort operation");
  a_bc_nosupply: assert property ((cmd_wr && q.ctrl[nfc_pkg::CTRL_RESET_N] && !q.ctrl[nfc_pkg::CTRL_SUPPLY] &&
      q.op == nfc_pkg::OP_NONE && q.pend[cbank] == nfc_pkg::P_NONE && cmd == nfc_pkg::C_BC) |=>
      (q.pend[$past(cbank)] == nfc_pkg::P_NONE && $stable(q.status)))
    else $error("blank check not ignored with supply low");
  a_erase_run: assert property ((cmd_wr && q.ctrl[nfc_pkg::CTRL_RESET_N] && q.ctrl[nfc_pkg::CTRL_SUPPLY] &&
      q.op == nfc_pkg::OP_NONE && q.pend[cbank] == nfc_pkg::P_ERASE && cmd == nfc_pkg::C_CONF && !q.prot[cblk]) |=>
      (q.op == nfc_pkg::OP_ERASE && q.mode[q.obank] == nfc_pkg::MODE_STATUS && q.timer == nfc_pkg::CY_ERASE - 16'h0001))
    else $error("erase confirm did not start controller");
  a_busy_ignore: assert property ((cmd_wr && q.ctrl[nfc_pkg::CTRL_RESET_N] && q.op != nfc_pkg::OP_NONE &&
      q.obank == cbank && q.pend[cbank] == nfc_pkg::P_NONE && (cmd == nfc_pkg::C_ERASE || cmd == nfc_pkg::C_PROG)) |=>
      q.pend[$past(cbank)] == nfc_pkg::P_NONE)
    else $error("busy bank accepted new command");
  a_protect_err: assert property ((cmd_wr && q.ctrl[nfc_pkg::CTRL_RESET_N] && q.ctrl[nfc_pkg::CTRL_SUPPLY] &&
      q.op == nfc_pkg::OP_NONE && q.pend[cbank] == nfc_pkg::P_PROG && q.prot[cblk]) |=>
      (q.op == nfc_pkg::OP_NONE && q.status[nfc_pkg::SR_PROT]))
    else $error("protected block program not refused");
endmodule

/* tb/nfc_host.sv */
// APB host model that issues register transfers to the flash command interpreter
`timescale 1ns/1ps
module nfc_host (
  input  wire logic        pclk,
  output logic             psel,
  output logic             penable,
  output logic             pwrite,
  output logic [7:0]       paddr,
  output logic [31:0]      pwdata,
  input  wire logic [31:0] prdata,
  input  wire logic        pready,
  input  wire logic        pslverr
);
  int tmo;
  logic err;

  // Idle bus at time zero; address and data parked on a toggling pattern, never left at the last value
  initial begin
    tmo = 0;
    err = 1'b0;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 8'h00;
    pwdata = 32'h0000_0000;
  end

  // One transfer: setup, access held until pready is sampled high, then release
  task automatic xfer(input logic w, input logic [7:0] a, input logic [31:0] d, output logic [31:0] r);
    int k;
    k = 0;
    @(posedge pclk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do begin
      @(posedge pclk);
      k++;
    end while (pready !== 1'b1 && k < 50);
    r = prdata;
    err = pslverr;
    if (k >= 50) tmo++;
    psel <= 1'b0;
    penable <= 1'b0;
    paddr <= ~a;
    pwdata <= ~d;
  endtask
endmodule

/* tb/tb_top.sv */
// Self-checking bench for the flash command interpreter, driving it through the APB host model
`timescale 1ns/1ps
module tb_top;
  logic        pclk;
  logic        presetn;
  logic        psel;
  logic        penable;
  logic        pwrite;
  logic [7:0]  paddr;
  logic [31:0] pwdata;
  logic [31:0] prdata;
  logic        pready;
  logic        pslverr;
  logic        controller_ready;
  logic [31:0] r;
  int          error_cnt;
  int          n_tests;

  nfc_host nfc_host_i (.pclk(pclk), .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
    .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr));
  nfc_cmd_if nfc_cmd_if_i (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .controller_ready(controller_ready));

  // 50 MHz clock
  initial pclk = 1'b0;
  always #10 pclk = ~pclk;

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    n_tests++;
    if (got !== exp) begin
      $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
      error_cnt++;
    end
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    logic [31:0] x;
    nfc_host_i.xfer(1'b1, a, d, x);
  endtask

  task automatic rd(input logic [7:0] a, output logic [31:0] d);
    nfc_host_i.xfer(1'b0, a, 32'h0000_0000, d);
  endtask

  // One flash bus write cycle at a word address
  task automatic fw(input logic [11:0] a, input logic [15:0] d);
    wr(nfc_pkg::OFS_ADDR, {20'h00000, a});
    wr(nfc_pkg::OFS_DATA, {16'h0000, d});
  endtask

  // Poll the ready bit under a bound; erase is the longest at 2000 cycles
  task automatic wait_ready();
    int k;
    k = 0;
    do begin
      rd(nfc_pkg::OFS_STAT, r);
      k++;
    end while (r[nfc_pkg::SR_READY] !== 1'b1 && k < 1500);
    if (k >= 1500) begin
      error_cnt++;
      results();
    end
  endtask

  task automatic results();
    error_cnt += nfc_host_i.tmo;
    $display("tests=%0d errors=%0d", n_tests, error_cnt);
    if (error_cnt == 0 && n_tests > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask

  // Main sequence; each step builds on the block state left by the previous one
  initial begin
    error_cnt = 0;
    n_tests = 0;
    presetn = 1'b0;
    repeat (20) @(posedge pclk);
    presetn <= 1'b1;
    rd(nfc_pkg::OFS_STAT, r);
    chk(r, 32'h0fff_f080);
    rd(8'h18, r);
    chk({31'h0, nfc_host_i.err}, 32'h1);
    wr(nfc_pkg::OFS_CTRL, 32'h3);
    // Wrong erase confirm, error bits survive an unrelated command until cleared
    fw(12'h000, 16'(nfc_pkg::C_ERASE));
    fw(12'h000, 16'h0000);
    rd(nfc_pkg::OFS_DATA, r);
    chk(r, 32'hb0);
    fw(12'h000, 16'(nfc_pkg::C_RDST));
    rd(nfc_pkg::OFS_STAT, r);
    chk(r[7:0], 8'hb0);
    fw(12'h000, 16'(nfc_pkg::C_CLRST));
    rd(nfc_pkg::OFS_STAT, r);
    chk(r[7:0], 8'h80);
    // Wrong blank check confirm flags both fail bits
    fw(12'h000, 16'(nfc_pkg::C_BC));
    fw(12'h000, 16'h0000);
    rd(nfc_pkg::OFS_STAT, r);
    chk(r[7:0], 8'hb0);
    fw(12'h000, 16'(nfc_pkg::C_CLRST));
    // Word program in block 1 clears its blank flag
    fw(12'h100, 16'(nfc_pkg::C_PROG));
    fw(12'h105, 16'h1234);
    rd(nfc_pkg::OFS_STAT, r);
    chk({r[7], r[10:8]}, 4'h2);
    wait_ready();
    chk(r[27:12], 16'hfffd);
    // Blank check on programmed block fails, bank stays in status mode
    fw(12'h1f0, 16'(nfc_pkg::C_BC));
    fw(12'h100, 16'(nfc_pkg::C_BCCONF));
    rd(nfc_pkg::OFS_STAT, r);
    chk({r[7], r[10:8]}, 4'h3);
    fw(12'h400, 16'(nfc_pkg::C_RDST));
    fw(12'h400, 16'(nfc_pkg::C_RDARR));
    rd(nfc_pkg::OFS_MODE, r);
    chk(r[3:0], 4'h5);
    wait_ready();
    chk(r[7:0], 8'ha0);
    fw(12'h100, 16'(nfc_pkg::C_CLRST));
    // Erase block 1; a program to the busy bank is ignored, read array to it is taken, other banks keep their own mode
    fw(12'h100, 16'(nfc_pkg::C_ERASE));
    fw(12'h1ff, 16'(nfc_pkg::C_CONF));
    fw(12'h000, 16'(nfc_pkg::C_PROG));
    fw(12'h400, 16'(nfc_pkg::C_RDST));
    rd(nfc_pkg::OFS_MODE, r);
    chk(r[19:0], 20'h00005);
    fw(12'h000, 16'(nfc_pkg::C_RDARR));
    rd(nfc_pkg::OFS_MODE, r);
    chk(r[3:0], 4'h4);
    rd(nfc_pkg::OFS_STAT, r);
    chk(r[7:0], 8'h00);
    wait_ready();
    chk(r[27:0], 28'hffff080);
    fw(12'h100, 16'(nfc_pkg::C_BC));
    fw(12'h100, 16'(nfc_pkg::C_BCCONF));
    wait_ready();
    chk(r[7:0], 8'h80);
    // Erase of a protected block aborts with protect error
    wr(nfc_pkg::OFS_PROT, 32'h0004);
    fw(12'h200, 16'(nfc_pkg::C_ERASE));
    fw(12'h200, 16'(nfc_pkg::C_CONF));
    rd(nfc_pkg::OFS_STAT, r);
    chk({r[27:12], r[10:8], r[7], r[1]}, {16'hffff, 3'h0, 2'h3});
    fw(12'h200, 16'(nfc_pkg::C_CLRST));
    // Word program into the protected block is refused the same way
    fw(12'h200, 16'(nfc_pkg::C_PROG));
    fw(12'h210, 16'h0000);
    rd(nfc_pkg::OFS_STAT, r);
    chk({r[27:12], r[10:8], r[7:0]}, {16'hffff, 3'h0, 8'h92});
    fw(12'h200, 16'(nfc_pkg::C_CLRST));
    // Blank check with supply low is dropped without any error
    wr(nfc_pkg::OFS_CTRL, 32'h2);
    fw(12'h100, 16'(nfc_pkg::C_BC));
    fw(12'h100, 16'(nfc_pkg::C_BCCONF));
    rd(nfc_pkg::OFS_STAT, r);
    chk(r[10:0], 11'h080);
    wr(nfc_pkg::OFS_CTRL, 32'h3);
    // Buffer program of two words at an aligned start in block 3
    fw(12'h300, 16'(nfc_pkg::C_BUF));
    rd(nfc_pkg::OFS_STAT, r);
    chk(r[7], 1'b1);
    fw(12'h300, 16'h0001);
    fw(12'h320, 16'haaaa);
    fw(12'h321, 16'h5555);
    fw(12'h300, 16'(nfc_pkg::C_CONF));
    wait_ready();
    chk({r[27:12], r[7:0]}, {16'hfff7, 8'h80});
    // Buffer data outside start..start+n aborts with program fail, array untouched
    fw(12'h400, 16'(nfc_pkg::C_BUF));
    fw(12'h400, 16'h0001);
    fw(12'h404, 16'h1111);
    fw(12'h407, 16'h2222);
    fw(12'h400, 16'(nfc_pkg::C_CONF));
    rd(nfc_pkg::OFS_STAT, r);
    chk({r[27:12], r[10:8], r[7], r[4]}, {16'hfff7, 3'h0, 2'h3});
    fw(12'h400, 16'(nfc_pkg::C_CLRST));
    // Reset pin asserted mid-erase aborts and leaves block 5 undefined
    fw(12'h500, 16'(nfc_pkg::C_ERASE));
    fw(12'h500, 16'(nfc_pkg::C_CONF));
    wr(nfc_pkg::OFS_CTRL, 32'h1);
    rd(nfc_pkg::OFS_STAT, r);
    chk({r[27:12], r[10:8], r[7]}, {16'hffd7, 3'h0, 1'b1});
    chk({31'h0, controller_ready}, 32'h1);
    wr(nfc_pkg::OFS_CTRL, 32'h3);
    // Factory program setup: status mode after confirm, then ready after the setup phase
    fw(12'h600, 16'(nfc_pkg::C_EFP));
    fw(12'h600, 16'(nfc_pkg::C_CONF));
    rd(nfc_pkg::OFS_STAT, r);
    chk({r[10:8], r[7]}, 4'ha);
    rd(nfc_pkg::OFS_MODE, r);
    chk(r[3:2], 2'h1);
    wait_ready();
    chk(r[7:0], 8'h80);
    results();
  end
endmodule
